// >>> logic/bias_rail_pkg.sv
// Shared constants for the bias rail I2C target and its bus controller
package bias_rail_pkg;
    // Bus target address and direction bit
    localparam logic [6:0] TARGET_ADDR = 7'h73;
    localparam int RW_BIT = 0;
    // Register map of the bias supply
    localparam logic [7:0] POS_RAIL_OFFSET = 8'h00;
    localparam logic [7:0] NEG_RAIL_OFFSET = 8'h01;
    localparam logic [7:0] DISCHARGE_APP_OFFSET = 8'h03;
    localparam int CODE_MSB = 4;
    localparam int CODE_WIDTH = 5;
    localparam int POS_DISCHARGE_BIT = 1;
    localparam int NEG_DISCHARGE_BIT = 0;
    localparam int APP_SELECT_BIT = 6;
    localparam logic [7:0] CODE_MAX = 8'h14;
    localparam logic [7:0] POS_RAIL_RESET = 8'h0A;
    localparam logic [7:0] NEG_RAIL_RESET = 8'h0A;
    localparam logic [7:0] DISCHARGE_APP_RESET = 8'h43;
    // Controller software registers (Avalon word addresses)
    localparam logic [1:0] CTRL_CMD_OFFSET = 2'h0;
    localparam logic [1:0] CTRL_STATUS_OFFSET = 2'h1;
    localparam logic [1:0] CTRL_WDATA_OFFSET = 2'h2;
    localparam logic [1:0] CTRL_RDATA_OFFSET = 2'h3;
    localparam int CMD_GO_BIT = 31;
    localparam int CMD_READ_BIT = 30;
    localparam int CMD_COUNT_LSB = 8;
    localparam int CMD_ADDR_LSB = 0;
    // Link timing: 400 kHz bus, quarter-period ticks at 125 MHz
    localparam int CLOCK_HZ = 125000000;
    localparam int SCL_HZ = 400000;
    localparam int QUARTER_CYCLES = CLOCK_HZ / (SCL_HZ * 4) + 1;
endpackage

// >>> logic/bias_rail_link_if.sv
// Two-wire link between the bus controller and the bias rail target
`timescale 1ns/100ps
interface bias_rail_link_if;
    logic scl_out;
    logic scl_oe;
    logic sda_in;
    logic sda_out;
    logic sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    // Open drain: a line is low when any enabled driver pulls it low
    assign scl = !(scl_oe && !scl_out);
    assign sda = !((sda_oe && !sda_out) || (dev_sda_oe && !dev_sda_out));
    assign sda_in = sda;
    modport controller (output scl_out, output scl_oe, output sda_out, output sda_oe,
        input sda_in);
    modport target (input scl, input sda, output dev_sda_out, output dev_sda_oe);
endinterface

// >>> logic/bias_rail_i2c_regs.sv
// I2C target and register file of the dual-rail bias supply
//
// How it works
// - Answer fixed address; bit 0 selects read
// - Write: address, register pointer, data, acks
// - Acknowledge every written data byte until stop
// - Read: pointer write, restart, return byte
// - Keep sending bytes while controller acknowledges
// - Positive code at 00h, bits 4..0
// - Negative code at 01h, bits 4..0
// - Reserved bits dropped on write, read zero
// - 03h holds discharge enables and application select
// - Defaults 0Ah, 0Ah and 43h after reset
`timescale 1ns/100ps
module bias_rail_i2c_regs
    import bias_rail_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    bias_rail_link_if.target link,
    output logic [bias_rail_pkg::CODE_WIDTH-1:0] positive_rail_code,
    output logic [bias_rail_pkg::CODE_WIDTH-1:0] negative_rail_code,
    output logic pos_rail_discharge_en,
    output logic neg_rail_discharge_en,
    output logic application_select
);
    import bias_rail_pkg::*;

    typedef enum logic [4:0] {
        IDLE = 5'b00001,
        SHIFT_IN = 5'b00010,
        ACK_OUT = 5'b00100,
        SHIFT_OUT = 5'b01000,
        ACK_IN = 5'b10000
    } tgt_state_type;

    tgt_state_type state_q, state_d;
    logic scl_q, sda_q;
    logic [7:0] shift_q, shift_d;
    logic [3:0] bits_q, bits_d;
    logic [1:0] phase_q, phase_d; // 0 address, 1 pointer, 2 data
    logic reading_q, reading_d;
    logic [7:0] ptr_q, ptr_d;
    logic [7:0] pos_q, pos_d, neg_q, neg_d, disc_q, disc_d;
    logic sda_oe_q, sda_oe_d;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    // Register readback; unmapped and reserved bits read as zero
    function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] p,
        input logic [7:0] n, input logic [7:0] d);
        case (addr)
            POS_RAIL_OFFSET: reg_read = p;
            NEG_RAIL_OFFSET: reg_read = n;
            DISCHARGE_APP_OFFSET: reg_read = d;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // Edge and condition detection on the sampled lines
    assign scl_rise = link.scl && !scl_q;
    assign scl_fall = !link.scl && scl_q;
    assign start_cond = link.scl && scl_q && sda_q && !link.sda;
    assign stop_cond = link.scl && scl_q && !sda_q && link.sda;

    // Protocol next state
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        bits_d = bits_q;
        phase_d = phase_q;
        reading_d = reading_q;
        ptr_d = ptr_q;
        pos_d = pos_q;
        neg_d = neg_q;
        disc_d = disc_q;
        sda_oe_d = sda_oe_q;
        // A start or stop overrides whatever byte was in flight
        if (start_cond) begin
            state_d = SHIFT_IN; // Repeated start too
            bits_d = 4'h0;
            phase_d = 2'd0;
            sda_oe_d = 1'b0;
        end else if (stop_cond) begin
            state_d = IDLE;
            sda_oe_d = 1'b0;
        end else begin
            case (state_q)
                IDLE: sda_oe_d = 1'b0;
                SHIFT_IN: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], link.sda}; // MSB first
                        bits_d = bits_q + 4'h1;
                    end else if (scl_fall && bits_q == 4'h8) begin
                        bits_d = 4'h0;
                        state_d = ACK_OUT;
                        sda_oe_d = 1'b1;
                        if (phase_q == 2'd0) begin
                            if (shift_q[7:1] == TARGET_ADDR) begin
                                reading_d = shift_q[RW_BIT];
                                phase_d = 2'd1;
                            end else begin
                                state_d = IDLE; // Not ours: stay off the bus
                                sda_oe_d = 1'b0;
                            end
                        end else if (phase_q == 2'd1) begin
                            ptr_d = shift_q;
                            phase_d = 2'd2;
                        end else begin
                            // Data byte: store, dropping reserved bits
                            case (ptr_q)
                                POS_RAIL_OFFSET: pos_d = {3'b000, shift_q[CODE_MSB:0]};
                                NEG_RAIL_OFFSET: neg_d = {3'b000, shift_q[CODE_MSB:0]};
                                DISCHARGE_APP_OFFSET: begin
                                    // Only the three defined bits are kept
                                    disc_d = 8'h00;
                                    disc_d[POS_DISCHARGE_BIT] = shift_q[POS_DISCHARGE_BIT];
                                    disc_d[NEG_DISCHARGE_BIT] = shift_q[NEG_DISCHARGE_BIT];
                                    disc_d[APP_SELECT_BIT] = shift_q[APP_SELECT_BIT];
                                end
                                default: ;
                            endcase
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                // Own acknowledge holds through one clock high, then the read path loads
                ACK_OUT: begin
                    if (scl_fall) begin
                        if (reading_q && phase_q == 2'd1) begin
                            state_d = SHIFT_OUT;
                            shift_d = reg_read(ptr_q, pos_q, neg_q, disc_q);
                            // First bit drives at once; the rest follow each fall
                            sda_oe_d = !shift_d[7];
                            bits_d = 4'h1;
                        end else begin
                            state_d = SHIFT_IN;
                            sda_oe_d = 1'b0;
                        end
                    end
                end
                // Next bit goes out after each falling clock; the ack slot follows the eighth
                SHIFT_OUT: begin
                    if (scl_fall) begin
                        if (bits_q == 4'h8) begin
                            state_d = ACK_IN;
                            sda_oe_d = 1'b0;
                            ptr_d = ptr_q + 8'h01;
                        end else begin
                            sda_oe_d = !shift_q[3'd7 - bits_q[2:0]];
                            bits_d = bits_q + 4'h1;
                        end
                    end
                end
                ACK_IN: begin
                    if (scl_rise) begin
                        if (link.sda) begin
                            state_d = IDLE; // Not acknowledged: wait for stop
                        end else begin
                            state_d = ACK_OUT; // Reuses the fall handling to load the next byte
                            sda_oe_d = 1'b0;
                        end
                    end
                end
                default: state_d = IDLE;
            endcase
        end
    end

    // Registers; defaults load on reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            shift_q <= 8'h00;
            bits_q <= 4'h0;
            phase_q <= 2'd0;
            reading_q <= 1'b0;
            ptr_q <= 8'h00;
            pos_q <= POS_RAIL_RESET;
            neg_q <= NEG_RAIL_RESET;
            disc_q <= DISCHARGE_APP_RESET;
            sda_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            scl_q <= link.scl;
            sda_q <= link.sda;
            shift_q <= shift_d;
            bits_q <= bits_d;
            phase_q <= phase_d;
            reading_q <= reading_d;
            ptr_q <= ptr_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
            disc_q <= disc_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    // Target only ever pulls low
    assign link.dev_sda_out = 1'b0;
    assign link.dev_sda_oe = sda_oe_q;

    // Rail codes and control bits come straight from their registers
    assign positive_rail_code = pos_q[CODE_MSB:0];
    assign negative_rail_code = neg_q[CODE_MSB:0];
    assign pos_rail_discharge_en = disc_q[POS_DISCHARGE_BIT];
    assign neg_rail_discharge_en = disc_q[NEG_DISCHARGE_BIT];
    assign application_select = disc_q[APP_SELECT_BIT];
endmodule // bias_rail_i2c_regs

// >>> logic/bias_rail_i2c_ctrl.sv
// I2C bus controller with Avalon-MM command registers
`timescale 1ns/100ps
module bias_rail_i2c_ctrl
    import bias_rail_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    bias_rail_link_if.controller link
);
    import bias_rail_pkg::*;

    typedef enum logic [5:0] {
        C_IDLE = 6'b000001,
        C_START = 6'b000010,
        C_BYTE = 6'b000100,
        C_RESTART = 6'b001000,
        C_STOP = 6'b010000,
        C_DONE = 6'b100000
    } ctl_state_type;

    ctl_state_type state_q, state_d;
    logic [15:0] div_q, div_d;
    logic [1:0] qtr_q, qtr_d;
    logic [3:0] bit_q, bit_d;
    logic [2:0] step_q, step_d; // 0 addr-w,1 ptr,2 data,3 addr-r,4 rdata
    logic [7:0] tx_q, tx_d, rx_q, rx_d;
    logic [7:0] ptr_q, ptr_d;
    logic [2:0] left_q, left_d;
    logic rd_q, rd_d, nack_q, nack_d;
    logic [31:0] wbuf_q, wbuf_d, rbuf_q, rbuf_d;
    logic scl_q, scl_d, sda_q, sda_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic tick;

    assign tick = (div_q == 16'(QUARTER_CYCLES - 1));

    // Bus slave, divider and link sequencer
    always_comb begin
        state_d = state_q;
        div_d = tick ? 16'h0000 : div_q + 16'h0001;
        qtr_d = qtr_q;
        bit_d = bit_q;
        step_d = step_q;
        tx_d = tx_q;
        rx_d = rx_q;
        ptr_d = ptr_q;
        left_d = left_q;
        rd_d = rd_q;
        nack_d = nack_q;
        wbuf_d = wbuf_q;
        rbuf_d = rbuf_q;
        scl_d = scl_q;
        sda_d = sda_q;
        rdata_d = rdata_q;
        // One wait cycle, then answer
        wait_d = 1'b1;
        if ((avs_read || avs_write) && wait_q) begin
            wait_d = 1'b0;
            case (avs_address)
                CTRL_STATUS_OFFSET: rdata_d = {30'h0, nack_q, state_q != C_IDLE};
                CTRL_WDATA_OFFSET: rdata_d = wbuf_q;
                CTRL_RDATA_OFFSET: rdata_d = rbuf_q;
                default: rdata_d = 32'h0;
            endcase
            if (avs_write && avs_address == CTRL_WDATA_OFFSET) begin
                wbuf_d = avs_writedata;
            end
            if (avs_write && avs_address == CTRL_CMD_OFFSET && avs_writedata[CMD_GO_BIT]
                && state_q == C_IDLE) begin
                state_d = C_START;
                qtr_d = 2'd0;
                rd_d = avs_writedata[CMD_READ_BIT];
                ptr_d = avs_writedata[CMD_ADDR_LSB +: 8];
                left_d = avs_writedata[CMD_COUNT_LSB +: 3];
                nack_d = 1'b0;
                rbuf_d = 32'h0;
            end
        end
        if (tick) begin
            qtr_d = qtr_q + 2'd1;
            case (state_q)
                C_IDLE, C_DONE: begin
                    qtr_d = 2'd0; // A new start always begins at its first quarter
                    scl_d = 1'b1;
                    sda_d = 1'b1;
                    if (state_q == C_DONE) state_d = C_IDLE;
                end
                C_START, C_RESTART: begin
                    // Quarters: release SDA, release SCL, pull SDA, pull SCL
                    if (qtr_q == 2'd0) sda_d = 1'b1;
                    if (qtr_q == 2'd1) scl_d = 1'b1;
                    if (qtr_q == 2'd2) sda_d = 1'b0;
                    if (qtr_q == 2'd3) begin
                        scl_d = 1'b0;
                        state_d = C_BYTE;
                        bit_d = 4'h0;
                        step_d = (state_q == C_RESTART) ? 3'd3 : 3'd0;
                        tx_d = {TARGET_ADDR, state_q == C_RESTART};
                    end
                end
                C_BYTE: begin
                    if (qtr_q == 2'd0) begin
                        if (bit_q < 4'h8) begin
                            sda_d = (step_q == 3'd4) ? 1'b1 : tx_q[3'd7 - bit_q[2:0]];
                        end else if (step_q == 3'd4) begin
                            sda_d = (left_q == 3'd1);
                        end else begin
                            sda_d = 1'b1;
                        end
                    end
                    if (qtr_q == 2'd1) scl_d = 1'b1;
                    if (qtr_q == 2'd2 && step_q == 3'd4 && bit_q < 4'h8) begin
                        rx_d = {rx_q[6:0], link.sda_in};
                    end
                    if (qtr_q == 2'd2 && bit_q == 4'h8 && step_q != 3'd4 && link.sda_in) begin
                        nack_d = 1'b1;
                    end
                    if (qtr_q == 2'd3) begin
                        scl_d = 1'b0;
                        bit_d = bit_q + 4'h1;
                        if (bit_q == 4'h8) begin
                            bit_d = 4'h0;
                            if (nack_q) state_d = C_STOP;
                            else if (step_q == 3'd0) begin
                                step_d = 3'd1;
                                tx_d = ptr_q;
                            end else if (step_q == 3'd1) begin
                                if (rd_q) state_d = C_RESTART;
                                else begin
                                    step_d = 3'd2;
                                    tx_d = wbuf_q[7:0];
                                end
                            end else if (step_q == 3'd3) step_d = 3'd4;
                            else begin
                                // Data byte finished; more follow while count remains
                                if (step_q == 3'd4) rbuf_d = {rbuf_q[23:0], rx_q};
                                else wbuf_d = {8'h00, wbuf_q[31:8]};
                                tx_d = wbuf_q[15:8];
                                left_d = left_q - 3'd1;
                                if (left_q <= 3'd1) state_d = C_STOP;
                            end
                        end
                    end
                end
                C_STOP: begin
                    if (qtr_q == 2'd0) sda_d = 1'b0;
                    if (qtr_q == 2'd1) scl_d = 1'b1;
                    if (qtr_q == 2'd3) begin
                        sda_d = 1'b1;
                        state_d = C_DONE;
                    end
                end
                default: state_d = C_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= C_IDLE;
            div_q <= 16'h0000;
            qtr_q <= 2'd0;
            bit_q <= 4'h0;
            step_q <= 3'd0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            ptr_q <= 8'h00;
            left_q <= 3'd0;
            rd_q <= 1'b0;
            nack_q <= 1'b0;
            wbuf_q <= 32'h0;
            rbuf_q <= 32'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            state_q <= state_d;
            div_q <= div_d;
            qtr_q <= qtr_d;
            bit_q <= bit_d;
            step_q <= step_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            ptr_q <= ptr_d;
            left_q <= left_d;
            rd_q <= rd_d;
            nack_q <= nack_d;
            wbuf_q <= wbuf_d;
            rbuf_q <= rbuf_d;
            scl_q <= scl_d;
            sda_q <= sda_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // Open-drain style: enable pulls the line low
    assign link.scl_out = 1'b0;
    assign link.scl_oe = !scl_q;
    assign link.sda_out = 1'b0;
    assign link.sda_oe = !sda_q;
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
endmodule // bias_rail_i2c_ctrl

// >>> test/bias_rail_monitor.sv
// Wire-level checks on the two-wire link between controller and target
`timescale 1ns/100ps
module bias_rail_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe
);
    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Start: data line falls while the clock line stays high
    sequence start_seq;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence clock_rise_seq;
        ##[1:400] $rose(scl);
    endsequence

    // Cycles since a start with no answer from the target; bounds the wait for the ack
    logic scl_q, scl_d, sda_q, sda_d;
    logic [11:0] wait_q, wait_d;
    always_comb begin
        scl_d = scl;
        sda_d = sda;
        wait_d = wait_q;
        if (dev_sda_oe) begin
            wait_d = 12'h000;
        end else if (scl && scl_q && sda_q && !sda) begin
            wait_d = 12'h001;
        end else if (wait_q != 12'h000 && wait_q != 12'hFFF) begin
            wait_d = wait_q + 12'h001;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            wait_q <= 12'h000;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
            wait_q <= wait_d;
        end
    end

    drive_low_a: assert property ($rose(dev_sda_oe) |-> !scl && !dev_sda_out)
        else $error("target took data line while clock high");
    ctrl_yield_a: assert property (dev_sda_oe && scl |-> !sda_oe)
        else $error("controller drives data line during target bit");
    hold_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("target data moved while clock high");
    start_free_a: assert property (start_seq |-> !dev_sda_oe)
        else $error("target drives during start");
    ack_wait_a: assert property (wait_q <= 12'd3100)
        else $error("target address acknowledge missing");
    idle_reset_a: assert property ($rose(rst_n) |-> scl && sda)
        else $error("lines not released after reset");
    start_clock_a: assert property (start_seq |-> ##[1:200] !scl)
        else $error("no clock after start");
    ack_span_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout clock_rise_seq)
        else $error("target released data before clock high");
endmodule // bias_rail_monitor

// >>> test/tb.sv
// Testbench joining the bus controller and the bias rail target over the link
`timescale 1ns/100ps
`define CHECK(what, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end
module tb;
    import bias_rail_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] avs_address = 2'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [CODE_WIDTH-1:0] positive_rail_code;
    logic [CODE_WIDTH-1:0] negative_rail_code;
    logic pos_rail_discharge_en;
    logic neg_rail_discharge_en;
    logic application_select;
    logic [2:0] disc_bits;
    assign disc_bits = {pos_rail_discharge_en, neg_rail_discharge_en, application_select};
    logic [31:0] rd_word;
    int error_cnt = 0;
    int num_checks = 0;

    always #4 clock = ~clock;

    bias_rail_link_if bias_rail_link_if_i();
    bias_rail_i2c_ctrl bias_rail_i2c_ctrl_i(.clock(clock), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .link(bias_rail_link_if_i));
    bias_rail_i2c_regs bias_rail_i2c_regs_i(.clock(clock), .rst_n(rst_n),
        .link(bias_rail_link_if_i), .positive_rail_code(positive_rail_code),
        .negative_rail_code(negative_rail_code), .pos_rail_discharge_en(pos_rail_discharge_en),
        .neg_rail_discharge_en(neg_rail_discharge_en), .application_select(application_select));
    bias_rail_monitor bias_rail_monitor_i(.clock(clock), .rst_n(rst_n),
        .scl(bias_rail_link_if_i.scl), .sda(bias_rail_link_if_i.sda),
        .scl_out(bias_rail_link_if_i.scl_out), .scl_oe(bias_rail_link_if_i.scl_oe),
        .sda_out(bias_rail_link_if_i.sda_out), .sda_oe(bias_rail_link_if_i.sda_oe),
        .dev_sda_out(bias_rail_link_if_i.dev_sda_out),
        .dev_sda_oe(bias_rail_link_if_i.dev_sda_oe));

    // Request holds until wait request is seen low at a rising edge; read data is taken there
    task automatic bus_write(input logic [1:0] addr, input logic [31:0] data);
        @(posedge clock);
        avs_address <= addr;
        avs_writedata <= data;
        avs_write <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic bus_read(input logic [1:0] addr, output logic [31:0] data);
        @(posedge clock);
        avs_address <= addr;
        avs_read <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        data = avs_readdata;
        avs_read <= 1'b0;
    endtask
    function automatic logic [31:0] cmd_word(input logic rd, input logic [2:0] cnt,
        input logic [7:0] ptr);
        logic [31:0] w;
        w = 32'h00000000;
        w[CMD_GO_BIT] = 1'b1;
        w[CMD_READ_BIT] = rd;
        w[CMD_COUNT_LSB +: 3] = cnt;
        w[CMD_ADDR_LSB +: 8] = ptr;
        return w;
    endfunction
    // Poll busy under a bound; the watchdog covers anything longer
    task automatic wait_idle();
        int polls;
        polls = 0;
        rd_word = 32'h00000001;
        while (rd_word[0] !== 1'b0 && polls < 40000) begin
            bus_read(CTRL_STATUS_OFFSET, rd_word);
            polls++;
        end
        `CHECK("busy flag", 1'b0, rd_word[0])
    endtask
    task automatic run_cmd(input logic rd, input logic [2:0] cnt, input logic [7:0] ptr);
        bus_write(CTRL_CMD_OFFSET, cmd_word(rd, cnt, ptr));
        wait_idle();
        `CHECK("nack flag", 1'b0, rd_word[1])
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        `CHECK("pos code", 5'h0A, positive_rail_code)
        `CHECK("neg code", 5'h0A, negative_rail_code)
        `CHECK("disc app", 3'h7, disc_bits)
        // Burst read across the gap at 02h exercises pointer advance and controller acks
        run_cmd(1'b1, 3'h4, POS_RAIL_OFFSET);
        bus_read(CTRL_RDATA_OFFSET, rd_word);
        `CHECK("burst read", 8'h0A, rd_word[31:24])
        `CHECK("burst read", 8'h0A, rd_word[23:16])
        `CHECK("burst read", 8'h43, rd_word[7:0] & 8'h43)
        // Burst write, reserved bits set, with a second go issued while busy
        bus_write(CTRL_WDATA_OFFSET, 32'hBDFF0CF4);
        bus_write(CTRL_CMD_OFFSET, cmd_word(1'b0, 3'h4, POS_RAIL_OFFSET));
        bus_write(CTRL_CMD_OFFSET, cmd_word(1'b1, 3'h1, NEG_RAIL_OFFSET));
        wait_idle();
        `CHECK("nack flag", 1'b0, rd_word[1])
        `CHECK("pos code", 5'h14, positive_rail_code)
        `CHECK("neg code", 5'h0C, negative_rail_code)
        `CHECK("disc app", 3'h2, disc_bits)
        bus_read(CTRL_RDATA_OFFSET, rd_word);
        // The write's go clears read data; an accepted second go would leave 0Ah there
        `CHECK("refused go", 32'h00000000, rd_word)
        // Single writes: lowest code, then discharge and application bits
        bus_write(CTRL_WDATA_OFFSET, 32'h00000000);
        run_cmd(1'b0, 3'h1, POS_RAIL_OFFSET);
        `CHECK("pos code", 5'h00, positive_rail_code)
        bus_write(CTRL_WDATA_OFFSET, 32'h00000042);
        run_cmd(1'b0, 3'h1, DISCHARGE_APP_OFFSET);
        `CHECK("disc app", 3'h5, disc_bits)
        `CHECK("neg code", 5'h0C, negative_rail_code)
        run_cmd(1'b1, 3'h1, DISCHARGE_APP_OFFSET);
        bus_read(CTRL_RDATA_OFFSET, rd_word);
        `CHECK("single read", 8'h42, rd_word[7:0] & 8'h43)
        report_and_stop();
    end

    // Watchdog sized above the roughly 70000 cycles the sequence needs
    initial begin
        repeat (95000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end
endmodule // tb
